// ---- design/dcf_pkg.sv ----
package dcf_pkg;

	// datapath widths
	localparam int DATA_W = 32;
	localparam int HALF_W = 16;
	localparam int DEST_W = 7;
	localparam int FLAG_W = 7;
	localparam int CNT_W = 16;

	// pipeline depths, issue cycle to writeback cycle
	localparam int CLIP_LAT = 2;
	localparam int FP_LAT = 3;

	// register bus
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFS_STATUS_WORD = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_RETIRED = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_SUPPRESSED = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_INFO = 8'h14;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// reset values
	localparam logic [FLAG_W-1:0] RST_FLAGS = 7'h00;
	localparam logic [FLAG_W-1:0] RST_MASK = 7'h00;
	localparam logic [CNT_W-1:0] RST_CNT = 16'h0000;

	// single-precision fields
	localparam int EXP_LSB = 23;
	localparam int QUIET_BIT = 22;
	localparam logic [7:0] EXP_ALL_ONES = 8'hff;
	localparam logic [7:0] EXP_ZERO = 8'h00;
	localparam logic [DATA_W-1:0] CANON_QNAN = 32'hffffffff;

	// info register fields
	localparam int INFO_FP_LSB = 8;

	typedef enum logic [3:0] {
		OP_DUAL_SCLIP = 4'h1,
		OP_DUAL_UCLIP = 4'h2,
		OP_FABS = 4'h4,
		OP_FABS_FLAGS = 4'h8
	} dcf_op_t;

	// bit 6 down to bit 0 of the exception vector
	typedef struct packed {
		logic output_flushed_flag;
		logic input_flushed_flag;
		logic invalid_flag;
		logic overflow_flag;
		logic underflow_flag;
		logic inexact_flag;
		logic divide_by_zero_flag;
	} dcf_flags_t;

	typedef struct packed {
		logic valid;
		dcf_op_t op;
		logic guard_used;
		logic [DATA_W-1:0] guard;
		logic [DEST_W-1:0] dest;
		logic [DATA_W-1:0] first_source;
		logic [DATA_W-1:0] second_source;
	} dcf_issue_t;

	typedef struct packed {
		logic valid;
		logic we;
		logic [DEST_W-1:0] dest;
		logic [DATA_W-1:0] data;
	} dcf_wb_t;

endpackage

// ---- design/dcf_clip_lane.sv ----
module dcf_clip_lane import dcf_pkg::*; #(
	parameter int W = HALF_W
) (
	// lane operands
	input wire logic [W-1:0] value,
	input wire logic [W-1:0] bound,
	input wire logic signed_mode,
	// lane result
	output logic [W-1:0] clipped
);

	logic signed [W:0] v;
	logic signed [W:0] lo;
	logic signed [W:0] hi;

	// one extra bit so an unsigned bound of all ones stays positive
	always_comb begin
		v = {value[W-1], value};
		hi = {1'b0, bound};
		lo = signed_mode ? ~{1'b0, bound} : '0;
		if (v < lo) begin
			clipped = lo[W-1:0];
		end else if (v > hi) begin
			clipped = hi[W-1:0];
		end else begin
			clipped = v[W-1:0];
		end
	end

endmodule // dcf_clip_lane

// ---- design/dcf_unit.sv ----
// Function
// - signed clip clamps each half from minus bound minus one to bound
// - unsigned clip: each signed half clamped between zero and bound
// - halves clipped apart, each into its matching destination half
// - with a guard, destination is written only when guard bit 0 is one
// - float abs value: negative inputs negated, others unchanged; here every NaN input returns the canonical quiet NaN instead
// - denormal input becomes zero and sets input flushed status flag
// - any exception raised by absolute value sets its status word flag
// - status flags sticky; only an explicit status write clears them
// - status flags change in the same cycle the destination is written
// - simultaneous updates OR together with the existing flag value
// - false guard leaves destination and status flags untouched
// - flags operation returns the would-be flags, status word untouched
// - vector bit 0 div-by-zero up to bit 6 output flushed; rest zero
//
// Our own choices: the register offsets and register access over AXI4-Lite.
module dcf_unit import dcf_pkg::*; #(
	parameter int CLIP_LATENCY = CLIP_LAT,
	parameter int FP_LATENCY = FP_LAT
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,

	// issue from the processor
	input wire dcf_issue_t issue,

	// flag updates of other float units retiring now
	input wire dcf_flags_t other_flag_updates,

	// writeback to the register file
	output dcf_wb_t dsp_wb,
	output dcf_wb_t fp_wb,

	// status word and interrupt
	output dcf_flags_t status_flags,
	output logic irq,

	// axi4-lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,

	// axi4-lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,

	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,

	// axi4-lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,

	// axi4-lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [DATA_W-1:0] rdata,
	output logic [1:0] rresp
);

	typedef struct packed {
		dcf_wb_t wb;
		dcf_flags_t upd;
	} dcf_fp_stage_t;

	typedef struct packed {
		dcf_wb_t [CLIP_LATENCY-1:0] dsp;
		dcf_fp_stage_t [FP_LATENCY-1:0] fp;
		dcf_flags_t psw;
		dcf_flags_t irq_st;
		dcf_flags_t irq_mask;
		logic [CNT_W-1:0] retired;
		logic [CNT_W-1:0] suppressed;
		logic aw_full;
		logic [ADDR_W-1:0] aw_addr;
		logic w_full;
		logic [DATA_W-1:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0] rresp;
	} dcf_state_t;

	dcf_state_t s_q;
	dcf_state_t s_d;

	// issue decode
	logic guard_ok;
	logic is_clip;
	logic is_fp;
	logic [DATA_W-1:0] clip_res;
	logic sclip_mode;

	// float absolute value
	logic [7:0] abs_exp;
	logic [22:0] abs_man;
	logic abs_denorm;
	logic abs_nan;
	logic abs_snan;
	logic [DATA_W-1:0] abs_res;
	dcf_flags_t abs_flags;

	// register bus internals
	logic do_write;
	logic do_read;
	dcf_flags_t flag_set;
	dcf_flags_t wr_flags;
	logic dsp_done;
	logic fp_done;
	logic dsp_skip;
	logic fp_skip;
	logic wr_status;
	logic wr_irq_st;
	logic wr_mask;

	// only bit 0 of the guard matters; no guard means always write
	assign guard_ok = !issue.guard_used || issue.guard[0];
	assign is_clip = issue.valid
		&& (issue.op == OP_DUAL_SCLIP || issue.op == OP_DUAL_UCLIP);
	assign is_fp = issue.valid
		&& (issue.op == OP_FABS || issue.op == OP_FABS_FLAGS);

	// uclip bounds above 0x7fff simply never clamp from above
	assign sclip_mode = issue.op == OP_DUAL_SCLIP;

	// bound from the low half only; upper bits of the bound are ignored
	dcf_clip_lane #(
		.W(HALF_W)
	) u_lane_hi (
		.value(issue.first_source[DATA_W-1:HALF_W]),
		.bound(issue.second_source[HALF_W-1:0]),
		.signed_mode(sclip_mode),
		.clipped(clip_res[DATA_W-1:HALF_W])
	);

	dcf_clip_lane #(
		.W(HALF_W)
	) u_lane_lo (
		.value(issue.first_source[HALF_W-1:0]),
		.bound(issue.second_source[HALF_W-1:0]),
		.signed_mode(sclip_mode),
		.clipped(clip_res[HALF_W-1:0])
	);

	assign abs_exp = issue.first_source[DATA_W-2:EXP_LSB];
	assign abs_man = issue.first_source[EXP_LSB-1:0];
	assign abs_denorm = (abs_exp == EXP_ZERO) && (abs_man != '0);
	assign abs_nan = (abs_exp == EXP_ALL_ONES) && (abs_man != '0);
	assign abs_snan = abs_nan && !abs_man[QUIET_BIT];

	always_comb begin
		abs_flags = '0;
		abs_flags.input_flushed_flag = abs_denorm;
		abs_flags.invalid_flag = abs_snan;
		if (abs_nan) begin
			// every NaN comes back as the one canonical quiet NaN
			abs_res = CANON_QNAN;
		end else if (abs_denorm) begin
			abs_res = '0;
		end else begin
			abs_res = {1'b0, issue.first_source[DATA_W-2:0]};
		end
	end

	// bus handshakes
	assign awready = !s_q.aw_full;
	assign wready = !s_q.w_full;
	assign arready = !s_q.rvalid;
	assign do_write = s_q.aw_full && s_q.w_full && !s_q.bvalid;
	assign do_read = arvalid && !s_q.rvalid;

	// what the retiring stage and the other units raise this edge
	assign flag_set = s_q.fp[FP_LATENCY-2].upd
		| other_flag_updates;
	assign wr_flags = s_q.w_data[FLAG_W-1:0];

	// only the low strobe matters: every writable field sits below bit 8
	// prot is not looked at; every access is treated alike
	assign wr_status = do_write && s_q.aw_addr == OFS_STATUS_WORD
		&& s_q.w_strb[0];
	assign wr_irq_st = do_write && s_q.aw_addr == OFS_IRQ_STATUS
		&& s_q.w_strb[0];
	assign wr_mask = do_write && s_q.aw_addr == OFS_IRQ_MASK
		&& s_q.w_strb[0];

	// retire accounting, taken from what enters the last stage
	assign dsp_done = s_q.dsp[CLIP_LATENCY-2].valid
		&& s_q.dsp[CLIP_LATENCY-2].we;
	assign fp_done = s_q.fp[FP_LATENCY-2].wb.valid
		&& s_q.fp[FP_LATENCY-2].wb.we;
	assign dsp_skip = s_q.dsp[CLIP_LATENCY-2].valid
		&& !s_q.dsp[CLIP_LATENCY-2].we;
	assign fp_skip = s_q.fp[FP_LATENCY-2].wb.valid
		&& !s_q.fp[FP_LATENCY-2].wb.we;

	always_comb begin
		s_d = s_q;

		// integer pipe
		for (int i = CLIP_LATENCY - 1; i > 0; i--) begin
			s_d.dsp[i] = s_q.dsp[i-1];
		end
		s_d.dsp[0].valid = is_clip;
		s_d.dsp[0].we = is_clip && guard_ok;
		s_d.dsp[0].dest = issue.dest;
		s_d.dsp[0].data = clip_res;

		// float pipe
		for (int i = FP_LATENCY - 1; i > 0; i--) begin
			s_d.fp[i] = s_q.fp[i-1];
		end
		s_d.fp[0].wb.valid = is_fp;
		s_d.fp[0].wb.we = is_fp && guard_ok;
		s_d.fp[0].wb.dest = issue.dest;
		if (issue.op == OP_FABS) begin
			s_d.fp[0].wb.data = abs_res;
		end else begin
			// upper bits stay zero in the returned vector
			s_d.fp[0].wb.data = {{(DATA_W - FLAG_W){1'b0}},
				abs_flags};
		end
		// status update only from a writing absolute value
		if (is_fp && guard_ok && issue.op == OP_FABS) begin
			s_d.fp[0].upd = abs_flags;
		end else begin
			s_d.fp[0].upd = '0;
		end

		// status word: sticky; a set in the same edge beats a write
		if (wr_status) begin
			s_d.psw = wr_flags | flag_set;
		end else begin
			s_d.psw = s_q.psw | flag_set;
		end

		// interrupt status: one-to-clear, set wins
		if (wr_irq_st) begin
			s_d.irq_st = (s_q.irq_st & ~wr_flags) | flag_set;
		end else begin
			s_d.irq_st = s_q.irq_st | flag_set;
		end

		if (wr_mask) begin
			s_d.irq_mask = wr_flags;
		end

		// counters wrap; writes to them are accepted and ignored
		s_d.retired = s_q.retired + CNT_W'(dsp_done) + CNT_W'(fp_done);
		s_d.suppressed = s_q.suppressed + CNT_W'(dsp_skip)
			+ CNT_W'(fp_skip);

		// write address and data may come in either order
		if (awvalid && !s_q.aw_full) begin
			s_d.aw_full = 1'b1;
			s_d.aw_addr = awaddr;
		end
		if (wvalid && !s_q.w_full) begin
			s_d.w_full = 1'b1;
			s_d.w_data = wdata;
			s_d.w_strb = wstrb;
		end
		if (do_write) begin
			s_d.aw_full = 1'b0;
			s_d.w_full = 1'b0;
			s_d.bvalid = 1'b1;
			if (s_q.aw_addr == OFS_STATUS_WORD
				|| s_q.aw_addr == OFS_IRQ_STATUS
				|| s_q.aw_addr == OFS_IRQ_MASK
				|| s_q.aw_addr == OFS_RETIRED
				|| s_q.aw_addr == OFS_SUPPRESSED
				|| s_q.aw_addr == OFS_INFO) begin
				s_d.bresp = RESP_OKAY;
			end else begin
				s_d.bresp = RESP_SLVERR;
			end
		end else if (s_q.bvalid && bready) begin
			s_d.bvalid = 1'b0;
		end

		// read returns the value held at the accepting edge
		if (do_read) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = RESP_OKAY;
			if (araddr == OFS_STATUS_WORD) begin
				s_d.rdata = {{(DATA_W - FLAG_W){1'b0}}, s_q.psw};
			end else if (araddr == OFS_IRQ_STATUS) begin
				s_d.rdata = {{(DATA_W - FLAG_W){1'b0}}, s_q.irq_st};
			end else if (araddr == OFS_IRQ_MASK) begin
				s_d.rdata = {{(DATA_W - FLAG_W){1'b0}}, s_q.irq_mask};
			end else if (araddr == OFS_RETIRED) begin
				s_d.rdata = {{(DATA_W - CNT_W){1'b0}}, s_q.retired};
			end else if (araddr == OFS_SUPPRESSED) begin
				s_d.rdata = {{(DATA_W - CNT_W){1'b0}}, s_q.suppressed};
			end else if (araddr == OFS_INFO) begin
				s_d.rdata = '0;
				s_d.rdata[INFO_FP_LSB-1:0] = 8'(CLIP_LATENCY);
				s_d.rdata[2*INFO_FP_LSB-1:INFO_FP_LSB] = 8'(FP_LATENCY);
			end else begin
				s_d.rdata = '0;
				s_d.rresp = RESP_SLVERR;
			end
		end else if (s_q.rvalid && rready) begin
			s_d.rvalid = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
			s_q.psw <= RST_FLAGS;
			s_q.irq_st <= RST_FLAGS;
			s_q.irq_mask <= RST_MASK;
			s_q.retired <= RST_CNT;
			s_q.suppressed <= RST_CNT;
		end else begin
			s_q <= s_d;
		end
	end

	// writeback appears with the status update of the same op
	assign dsp_wb = s_q.dsp[CLIP_LATENCY-1];
	assign fp_wb = s_q.fp[FP_LATENCY-1].wb;
	assign status_flags = s_q.psw;
	assign irq = |(s_q.irq_st & s_q.irq_mask);

	assign bvalid = s_q.bvalid;
	assign bresp = s_q.bresp;
	assign rvalid = s_q.rvalid;
	assign rdata = s_q.rdata;
	assign rresp = s_q.rresp;

endmodule // dcf_unit

// ---- tb/dcf_regfile.sv ----
module dcf_regfile import dcf_pkg::*; (
	// clock
	input wire logic clk,
	// writebacks from the unit
	input wire dcf_wb_t dsp_wb,
	input wire dcf_wb_t fp_wb,
	// bench lookup
	input wire logic [DEST_W-1:0] rd_idx,
	output logic [DATA_W-1:0] rd_val
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [DATA_W-1:0] regs_q [2**DEST_W];
	// distinct start values make a skipped write visible
	initial begin
		for (int i = 0; i < 2**DEST_W; i++) begin
			regs_q[i] = 32'h5a5a0000 | i;
		end
	end
	always @(posedge clk) begin
		if (dsp_wb.valid && dsp_wb.we) begin
			regs_q[dsp_wb.dest] <= dsp_wb.data;
		end
		if (fp_wb.valid && fp_wb.we) begin
			regs_q[fp_wb.dest] <= fp_wb.data;
		end
	end
	assign rd_val = regs_q[rd_idx];
endmodule // dcf_regfile

// ---- tb/dcf_unit_chk.sv ----
module dcf_unit_chk import dcf_pkg::*; #(
	parameter int CL = 2,
	parameter int FL = 3
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// watched ports
	input wire dcf_issue_t issue,
	input wire dcf_flags_t other_flag_updates,
	input wire dcf_wb_t dsp_wb,
	input wire dcf_wb_t fp_wb,
	input wire dcf_flags_t status_flags,
	input wire logic awvalid,
	input wire logic wvalid
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	logic clip_i;
	logic fp_i;
	logic g_ok;
	logic denorm;
	assign clip_i = issue.valid
		&& issue.op inside {OP_DUAL_SCLIP, OP_DUAL_UCLIP};
	assign fp_i = issue.valid && issue.op inside {OP_FABS, OP_FABS_FLAGS};
	assign g_ok = !issue.guard_used || issue.guard[0];
	assign denorm = issue.first_source[30:23] == EXP_ZERO
		&& issue.first_source[22:0] != 0;
	// a status write lands one edge after the bus lets go
	sequence s_bus_quiet;
		!(awvalid || wvalid) [*2];
	endsequence
	sequence s_flushed;
		##FL (fp_wb.valid && fp_wb.data == 0
			&& status_flags.input_flushed_flag);
	endsequence
	a_clip_guard: assert property (
		clip_i |-> ##CL dsp_wb.valid && dsp_wb.we == $past(g_ok, CL))
		else $error("clip writeback or enable wrong");
	a_fp_retire: assert property (
		fp_i |-> ##FL fp_wb.valid && fp_wb.dest == $past(issue.dest, FL))
		else $error("float result did not retire on time");
	a_flush_status: assert property (
		fp_i && g_ok && issue.op == OP_FABS && denorm |-> s_flushed)
		else $error("denormal input not flushed");
	a_abs_sign: assert property (
		fp_wb.valid && fp_wb.we && $past(issue.op, FL) == OP_FABS
		|-> !fp_wb.data[31] || fp_wb.data == CANON_QNAN)
		else $error("absolute value kept a sign");
	a_vector_zeros: assert property (
		fp_wb.valid && $past(issue.op, FL) == OP_FABS_FLAGS
		|-> fp_wb.data[31:7] == 0)
		else $error("flag vector upper bits set");
	a_status_kept: assert property (
		fp_wb.valid && (!fp_wb.we || $past(issue.op, FL) == OP_FABS_FLAGS)
		&& $past(other_flag_updates) == 0 |-> $stable(status_flags))
		else $error("status changed without cause");
	a_flags_sticky: assert property (
		s_bus_quiet |=> (status_flags & $past(status_flags))
		== $past(status_flags))
		else $error("status flag cleared without write");
	a_updates_ored: assert property (
		other_flag_updates != 0 |=> (status_flags
		& $past(other_flag_updates)) == $past(other_flag_updates))
		else $error("outside flag update lost");
endmodule // dcf_unit_chk
bind dcf_unit dcf_unit_chk #(.CL(CLIP_LATENCY), .FL(FP_LATENCY)) u_chk (
	.clk(clk), .rst(rst), .issue(issue),
	.other_flag_updates(other_flag_updates), .dsp_wb(dsp_wb),
	.fp_wb(fp_wb), .status_flags(status_flags),
	.awvalid(awvalid), .wvalid(wvalid)
);

// ---- tb/dcf_unit_bench.sv ----
module dcf_unit_bench import dcf_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {
		dcf_op_t o;
		logic g;
		logic [31:0] a, b, e;
	} dcf_case_t;
	localparam dcf_op_t SC = OP_DUAL_SCLIP, UC = OP_DUAL_UCLIP;
	localparam dcf_op_t FA = OP_FABS, FF = OP_FABS_FLAGS;
	// clip bounds kept in range
	dcf_case_t tbl [17] = '{
		'{SC, 1'h1, 32'h00800080, 32'h7f, 32'h007f007f},
		'{SC, 1'h1, 32'h80008000, 32'h3ff, 32'hfc00fc00},
		'{SC, 1'h1, 32'h7fff8000, 32'h7fff, 32'h7fff8000},
		'{SC, 1'h0, 32'h00800080, 32'h7ffe, 32'h5a5a0003},
		'{UC, 1'h1, 32'h80008000, 32'h3ff, 32'h0},
		'{UC, 1'h1, 32'h800003fe, 32'h3ff, 32'h3fe},
		'{UC, 1'h1, 32'h7fff7fff, 32'hffff, 32'h7fff7fff},
		'{FF, 1'h1, 32'h00400000, 32'h0, 32'h20},
		'{FF, 1'h1, 32'hffbfffff, 32'h0, 32'h10},
		'{FA, 1'h0, 32'h00400000, 32'h0, 32'h5a5a0009},
		'{FA, 1'h1, 32'hbf800000, 32'h0, 32'h3f800000},
		'{FA, 1'h1, 32'h00400000, 32'h0, 32'h0},
		'{FA, 1'h1, 32'hffffffff, 32'h0, 32'hffffffff},
		'{FA, 1'h1, 32'hffbfffff, 32'h0, 32'hffffffff},
		'{FA, 1'h1, 32'hff7fffff, 32'h0, 32'h7f7fffff},
		'{FA, 1'h1, 32'h80000000, 32'h0, 32'h0},
		'{UC, 1'h1, 32'h000f03fe, 32'h3ff, 32'h000f03fe}
	};
	logic clk = 1'h0;
	logic rst = 1'h1;
	dcf_issue_t issue = '0;
	dcf_flags_t other_flag_updates = '0;
	dcf_wb_t dsp_wb, fp_wb;
	dcf_flags_t status_flags;
	logic irq, awready, wready, bvalid, arready, rvalid;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0;
	logic [7:0] awaddr = '0, araddr = '0;
	logic [2:0] awprot = '0, arprot = '0;
	logic [3:0] wstrb = 4'hf;
	logic [31:0] wdata = '0, rdata, rd_val;
	logic [1:0] bresp, rresp, r;
	logic [6:0] rd_idx = '0;
	int errors = 0, n_compared = 0;
	dcf_unit u_dcf_unit (.*);
	dcf_regfile u_dcf_regfile (.*);
	initial forever #25 clk = ~clk;
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic cmp(input string w, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("FAIL %s expected %h seen %h", w, e, g);
		end
	endtask
	// every handshake wait is capped so a hang ends the run
	task automatic bound(inout int n);
		n++;
		if (n > 30) begin
			errors++;
			stop_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic [2:0] s;
		n = 0;
		s = '0;
		@(posedge clk);
		awvalid <= 1'h1;
		awaddr <= a;
		wvalid <= 1'h1;
		wdata <= d;
		bready <= 1'h1;
		while (!s[0]) begin
			bound(n);
			@(negedge clk);
			s = {awready, wready, bvalid};
			r = bresp;
			@(posedge clk);
			if (s[2]) awvalid <= 1'h0;
			if (s[1]) wvalid <= 1'h0;
			if (s[0]) bready <= 1'h0;
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		int n;
		logic [1:0] s;
		logic [31:0] d;
		n = 0;
		s = '0;
		@(posedge clk);
		arvalid <= 1'h1;
		araddr <= a;
		rready <= 1'h1;
		while (!s[0]) begin
			bound(n);
			@(negedge clk);
			s = {arready, rvalid};
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (s[1]) arvalid <= 1'h0;
			if (s[0]) rready <= 1'h0;
		end
		cmp("rdata", e, d);
		cmp("rresp", 32'(er), 32'(r));
	endtask
	task automatic op(input dcf_op_t o, input logic g, input logic [6:0] t,
		input logic [31:0] a, input logic [31:0] b);
		@(posedge clk);
		issue <= '{1'h1, o, 1'h1, {31'h0, g}, t, a, b};
	endtask
	task automatic idle(input int c);
		@(posedge clk);
		issue.valid <= 1'h0;
		repeat (c) @(posedge clk);
	endtask
	// back to back issue, both pipes may retire in one cycle
	task automatic run(input int lo, input int hi);
		for (int i = lo; i < hi; i++) begin
			op(tbl[i].o, tbl[i].g, 7'(i), tbl[i].a, tbl[i].b);
		end
		idle(4);
		@(negedge clk);
		for (int i = lo; i < hi; i++) begin
			rd_idx = 7'(i);
			#1;
			cmp("dest", tbl[i].e, rd_val);
		end
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		rchk(OFS_STATUS_WORD, 32'h0, RESP_OKAY);
		rchk(OFS_INFO, {16'h0, 8'(FP_LAT), 8'(CLIP_LAT)}, RESP_OKAY);
		rchk(8'h40, 32'h0, RESP_SLVERR);
		wr(8'h40, 32'h1);
		cmp("bresp", 32'(RESP_SLVERR), 32'(r));
		$display("test registers done");
		run(0, 10);
		cmp("status", 32'h0, 32'(status_flags));
		$display("test guarded and flag ops done");
		run(10, 17);
		cmp("status", 32'h30, 32'(status_flags));
		$display("test abs values done");
		cmp("irq", 32'h0, 32'(irq));
		wr(OFS_IRQ_MASK, 32'h20);
		cmp("bresp", 32'(RESP_OKAY), 32'(r));
		@(negedge clk);
		cmp("irq", 32'h1, 32'(irq));
		wr(OFS_IRQ_STATUS, 32'h20);
		@(negedge clk);
		cmp("irq", 32'h0, 32'(irq));
		rchk(OFS_IRQ_STATUS, 32'h10, RESP_OKAY);
		rchk(OFS_STATUS_WORD, 32'h30, RESP_OKAY);
		wr(OFS_STATUS_WORD, 32'h0);
		rchk(OFS_STATUS_WORD, 32'h0, RESP_OKAY);
		$display("test interrupt done");
		op(FA, 1'h1, 7'h14, 32'h00400000, 32'h0);
		idle(0);
		@(posedge clk);
		other_flag_updates <= 7'h01;
		@(posedge clk);
		other_flag_updates <= 7'h00;
		rchk(OFS_STATUS_WORD, 32'h21, RESP_OKAY);
		rchk(OFS_RETIRED, 32'h10, RESP_OKAY);
		rchk(OFS_SUPPRESSED, 32'h2, RESP_OKAY);
		$display("test merged flags done");
		stop_test();
	end
endmodule // dcf_unit_bench
